// ---- logic/quad_dac_serial_load_control.sv ----
// Quad DAC serial load, double buffer, clear and AXI4-Lite control
//
// Contract
// - Bipolar: pin high offset binary, low twos
// - Unipolar ranges always straight binary
// - Frame sync low: shift on falling clock
// - Frame sync rise latches word, acts
// - Load held low: update on sync rise
// - Load high defers; falling load updates all
// - Clear low forces zero or midscale
// - Readback/daisy mode shifts register onto output
// - Output changes on rising edge, host samples falling
`timescale 1ns/10ps
module quad_dac_serial_load_control (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [dacfe_pkg::ADDR_BITS-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [dacfe_pkg::ADDR_BITS-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic FRAME_SYNC_N,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  input wire logic LOAD_OUTPUTS_N,
  input wire logic CLEAR_N,
  input wire logic BIPOLAR_CODING_SELECT,
  output logic [dacfe_pkg::CH_COUNT*dacfe_pkg::CODE_BITS-1:0] DAC_CODE
);
  import dacfe_pkg::*;
  // --------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------------
  logic [PIN_COUNT-1:0] pins;
  logic sync_s, sclk_s, serial_data_in_s, load_s, clear_s, coding_s;
  logic sync_d, sclk_d, load_d;
  logic sync_rise, sclk_fall, sclk_rise, load_fall;
  pin_sync #(.WIDTH(PIN_COUNT), .RESET_VAL(PIN_RESET)) u_pin_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .din({FRAME_SYNC_N, SERIAL_CLK, SERIAL_DATA_IN, LOAD_OUTPUTS_N,
          CLEAR_N, BIPOLAR_CODING_SELECT}),
    .dout(pins)
  );
  assign {sync_s, sclk_s, serial_data_in_s, load_s, clear_s, coding_s} = pins;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync_d <= 1'b1;
      sclk_d <= 1'b0;
      load_d <= 1'b1;
    end else begin
      sync_d <= sync_s;
      sclk_d <= sclk_s;
      load_d <= load_s;
    end
  end
  assign sync_rise = sync_s && !sync_d;
  assign sclk_fall = sclk_d && !sclk_s && !sync_s;
  assign sclk_rise = !sclk_d && sclk_s && !sync_s;
  assign load_fall = load_d && !load_s;
  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  logic [CTRL_BITS-1:0] ctrl;
  logic clear_mid, rb_en;
  logic [CH_COUNT-1:0] unipolar;
  assign clear_mid = ctrl[CTRL_MID_POS];
  assign unipolar = ctrl[CTRL_UNI_POS +: CH_COUNT];
  assign rb_en = ctrl[CTRL_RB_POS];
  // --------------------------------------------------------------------
  // Serial shift path
  // --------------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_reg;
  logic shift_msb;
  logic [CH_BITS-1:0] word_ch;
  logic [CODE_BITS-1:0] word_data;
  logic [15:0] frame_count;
  assign shift_msb = shift_reg[WORD_BITS-1];
  assign word_ch = shift_reg[CH_POS +: CH_BITS];
  assign word_data = shift_reg[CODE_BITS-1:0];
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift_reg <= '0;
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], serial_data_in_s};
    end
  end
  // Old contents leave MSB first, so the chain passes words on
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SERIAL_DATA_OUT <= 1'b0;
    end else if (sclk_rise) begin
      SERIAL_DATA_OUT <= rb_en && shift_msb;
    end
  end
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      frame_count <= 16'h0000;
    end else if (sync_rise) begin
      frame_count <= frame_count + 16'h0001;
    end
  end
  // --------------------------------------------------------------------
  // Double buffer, clear and coding, one slice per channel
  // --------------------------------------------------------------------
  logic [CH_COUNT-1:0][CODE_BITS-1:0] input_reg, dac_reg, code_out;
  logic [CH_COUNT-1:0][CODE_BITS-1:0] clear_code;
  logic [CH_COUNT-1:0] twos;
  generate
    for (genvar i = 0; i < CH_COUNT; i++) begin : g_ch
      // Twos complement only for bipolar channels with the pin low
      assign twos[i] = !unipolar[i] && !coding_s;
      assign clear_code[i] = {clear_mid ^ twos[i], {(CODE_BITS-1){1'b0}}};
      always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          input_reg[i] <= '0;
        end else if (sync_rise && word_ch == CH_BITS'(i)) begin
          input_reg[i] <= word_data;
        end
      end
      // Clear outranks loads; input register is kept for later
      always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          dac_reg[i] <= '0;
        end else if (!clear_s) begin
          dac_reg[i] <= clear_code[i];
        end else if (load_fall) begin
          dac_reg[i] <= (sync_rise && word_ch == CH_BITS'(i)) ?
                        word_data : input_reg[i];
        end else if (sync_rise && !load_s && word_ch == CH_BITS'(i)) begin
          dac_reg[i] <= word_data;
        end
      end
      // Converter always sees straight binary
      always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          code_out[i] <= '0;
        end else begin
          code_out[i] <= dac_reg[i] ^ {twos[i], {(CODE_BITS-1){1'b0}}};
        end
      end
    end
  endgenerate
  assign DAC_CODE = code_out;
  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  logic aw_held, w_held;
  logic [ADDR_BITS-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  // Address and data accepted in either order, one write in flight
  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY = !w_held;
  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && !w_held) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= CTRL_RESET;
    end else if (do_write && aw_addr == CTRL_OFS && w_strb[0]) begin
      ctrl <= w_data[CTRL_BITS-1:0];
    end
  end
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (aw_addr == CTRL_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end
  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp = RESP_OKAY;
    if (S_AXI_ARADDR == CTRL_OFS) begin
      next_rdata[CTRL_BITS-1:0] = ctrl;
    end else if (S_AXI_ARADDR == STATUS_OFS) begin
      next_rdata[15:0] = frame_count;
      next_rdata[STAT_ACTIVE_POS] = !sync_s;
    end else if ((S_AXI_ARADDR & BLOCK_MASK) == INPUT_BASE) begin
      next_rdata[CODE_BITS-1:0] = input_reg[S_AXI_ARADDR[3:2]];
    end else if ((S_AXI_ARADDR & BLOCK_MASK) == DAC_BASE) begin
      next_rdata[CODE_BITS-1:0] = dac_reg[S_AXI_ARADDR[3:2]];
    end else begin
      next_rresp = RESP_SLVERR;
    end
  end
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
  // --------------------------------------------------------------------
  // Assertions and covers
  // --------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic [CODE_BITS-1:0] dac0, code0;
  assign dac0 = dac_reg[0];
  assign code0 = code_out[0];
  a_shift_on_fall: assert property (
    sclk_fall |=> shift_reg[0] == $past(serial_data_in_s))
    else $error("serial bit not shifted in on falling clock");
  a_idle_hold: assert property (
    sync_s |=> $stable(shift_reg))
    else $error("shift register moved while frame sync high");
  a_frame_latch: assert property (
    sync_rise |=> input_reg[$past(word_ch)] == $past(word_data))
    else $error("input register not loaded at frame end");
  a_load_low_update: assert property (
    sync_rise && !load_s && clear_s
      |=> dac_reg[$past(word_ch)] == $past(word_data))
    else $error("DAC register not updated with load low");
  a_deferred_hold: assert property (
    sync_rise && load_s && clear_s |=> $stable(dac_reg))
    else $error("DAC register changed while load held high");
  a_load_all: assert property (
    load_fall && clear_s && !sync_rise |=> dac_reg == $past(input_reg))
    else $error("falling load did not update all channels");
  a_clear_force: assert property (
    !clear_s ##1 !clear_s |-> dac_reg == $past(clear_code))
    else $error("clear did not force the DAC registers");
  a_readback_out: assert property (
    sclk_rise && rb_en |=> SERIAL_DATA_OUT == $past(shift_msb) [*1]
      ##1 (SERIAL_DATA_OUT == $past(SERIAL_DATA_OUT) || $past(sclk_rise)))
    else $error("serial output wrong after rising clock");
  a_out_on_rise: assert property (
    !sclk_rise |=> $stable(SERIAL_DATA_OUT))
    else $error("serial output changed off a rising clock");
  a_twos_flip: assert property (
    !unipolar[0] && !coding_s |=> code0 == ($past(dac0) ^ 16'h8000))
    else $error("twos complement coding not applied");
  a_straight: assert property (
    unipolar[0] || coding_s |=> code0 == $past(dac0))
    else $error("straight or offset binary code altered");
  c_frame: cover property (sclk_fall ##[1:20] sync_rise);
  c_load_fall: cover property (sync_rise && load_s ##[1:50] load_fall);
  c_clear: cover property (!clear_s ##1 clear_s);
  c_readback: cover property (sclk_rise && rb_en && shift_msb);
endmodule

// ---- logic/dacfe_pkg.sv ----
// Shared constants for the quad DAC serial load front end
package dacfe_pkg;
  // --------------------------------------------------------------------
  // Channel and word layout
  // --------------------------------------------------------------------
  localparam int CH_COUNT = 4;
  localparam int CH_BITS = 2;
  localparam int CODE_BITS = 16;
  localparam int WORD_BITS = 24;
  localparam int CH_POS = 16;
  // --------------------------------------------------------------------
  // Register map, byte addresses
  // --------------------------------------------------------------------
  localparam int ADDR_BITS = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INPUT_BASE = 8'h10;
  localparam logic [7:0] DAC_BASE = 8'h20;
  localparam logic [7:0] BLOCK_MASK = 8'hF0;
  // CTRL fields
  localparam int CTRL_MID_POS = 0;
  localparam int CTRL_UNI_POS = 1;
  localparam int CTRL_RB_POS = 5;
  localparam int CTRL_BITS = 6;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 6'h00;
  // STATUS fields
  localparam int STAT_ACTIVE_POS = 16;
  // --------------------------------------------------------------------
  // Bus answers and pin reset levels
  // --------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Order: frame sync, sclk, serial_data_in, load, clear, coding select
  localparam int PIN_COUNT = 6;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h27;
endpackage

// ---- logic/pin_sync.sv ----
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ---- tb/serial_host_model.sv ----
// Host serial port model: frame sync, serial clock and data toward the DAC
`timescale 1ns/10ps
module serial_host_model (
  input wire logic clk,
  output logic frame_sync_n,
  output logic sclk,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  // 160 ns link period, far below the device's top rate
  localparam int HALF = 4;
  initial begin
    frame_sync_n = 1'b1;
    sclk = 1'b0;
    serial_data_in = 1'b0;
  end
  // ------------------------------------------------------------
  // One frame, MSB first; returns the bits seen on the data out
  // ------------------------------------------------------------
  task automatic send(input logic [23:0] w, output logic [23:0] got);
    @(posedge clk);
    frame_sync_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 23; i >= 0; i--) begin
      serial_data_in <= w[i];
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      got[i] = serial_data_out;
      sclk <= 1'b0;
      repeat (HALF) @(posedge clk);
    end
    frame_sync_n <= 1'b1;
    // Data line must not keep looking like the last bit
    serial_data_in <= ~w[0];
    repeat (2 * HALF) @(posedge clk);
  endtask
  // Clock pulses and noise with frame sync high
  task automatic idle_clocks(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      serial_data_in <= 1'($urandom);
      sclk <= ~sclk;
      repeat (HALF) @(posedge clk);
    end
  endtask
endmodule

// ---- tb/quad_dac_serial_load_control_tb.sv ----
// Self-checking bench for the quad DAC serial load front end
`timescale 1ns/10ps
module quad_dac_serial_load_control_tb;
  import dacfe_pkg::*;
  logic core_clk, sys_rst, fs_n, sclk, serial_data_in, serial_data_out, load_n, clear_n, coding;
  logic [ADDR_BITS-1:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [63:0] dac_code;
  logic [23:0] got, last_word;
  int miscompares, cmp_count, ctrl, frames;
  int inp[4], dac[4];
  quad_dac_serial_load_control uut (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .FRAME_SYNC_N(fs_n), .SERIAL_CLK(sclk),
    .SERIAL_DATA_IN(serial_data_in), .SERIAL_DATA_OUT(serial_data_out),
    .LOAD_OUTPUTS_N(load_n), .CLEAR_N(clear_n),
    .BIPOLAR_CODING_SELECT(coding), .DAC_CODE(dac_code));
  serial_host_model host (.clk(core_clk), .frame_sync_n(fs_n),
    .sclk(sclk), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic hang(input string m);
    miscompares++;
    $display("MISMATCH %0t %s timed out", $time, m);
    test_done();
  endtask
  // ------------------------------------------------------------
  // AXI4-Lite master
  // ------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    if (bvalid !== 1'b1) hang("write");
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    if (rvalid !== 1'b1) hang("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic setctrl(input int v);
    logic [1:0] r;
    axw(CTRL_OFS, 32'(v), r);
    chk(32'(r), 32'(RESP_OKAY), "ctrl write");
    ctrl = v;
  endtask
  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  // Straight binary seen at the outputs for a stored raw code
  function automatic logic [15:0] outc(int c);
    logic flip;
    flip = !ctrl[1 + c] && !coding;
    return 16'(dac[c]) ^ {flip, 15'h0000};
  endfunction
  task automatic check_all();
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge core_clk);
    for (int c = 0; c < 4; c++) begin
      chk(32'(dac_code[16*c +: 16]), 32'(outc(c)), "code");
      axr(INPUT_BASE + 8'(4 * c), d, r);
      chk(d, 32'(inp[c]), "input reg");
      axr(DAC_BASE + 8'(4 * c), d, r);
      chk(d, 32'(dac[c]), "dac reg");
    end
  endtask
  task automatic frame(input int c, input logic [15:0] code);
    logic [23:0] w;
    w = {6'($urandom), 2'(c), code};
    host.send(w, got);
    chk(32'(got), ctrl[5] ? 32'(last_word) : 32'h0, "sdo");
    last_word = w;
    frames++;
    inp[c] = int'(code);
    if (load_n === 1'b0) dac[c] = int'(code);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(26271));
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    load_n = 1'b1;
    clear_n = 1'b1;
    coding = 1'b1;
    last_word = 24'h0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    check_all();
    axr(CTRL_OFS, d, r);
    chk(d, 32'(CTRL_RESET), "ctrl reset");
    axr(8'h08, d, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    chk(d, 32'h00000000, "unmapped data");
    axw(STATUS_OFS, 32'hFFFFFFFF, r);
    chk(32'(r), 32'(RESP_SLVERR), "read-only write");
    $display("test reset done");
    load_n <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      coding <= 1'(i / 4);
      setctrl(((i * 7) % 16) * 2);
      frame(i % 4, 16'($urandom));
      check_all();
    end
    $display("test immediate load done");
    load_n <= 1'b1;
    for (int c = 0; c < 4; c++) frame(c, 16'($urandom));
    check_all();
    load_n <= 1'b0;
    dac = inp;
    check_all();
    $display("test deferred load done");
    coding <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      setctrl(m ? 32'h0B : 32'h00);
      clear_n <= 1'b0;
      for (int c = 0; c < 4; c++) begin
        dac[c] = int'({1'(m) ^ (!ctrl[1 + c]), 15'h0000});
      end
      check_all();
      clear_n <= 1'b1;
      check_all();
    end
    $display("test clear done");
    setctrl(32'h20);
    host.idle_clocks(10);
    frame(1, 16'($urandom));
    frame(2, 16'hFFFF);
    check_all();
    $display("test readback done");
    axr(STATUS_OFS, d, r);
    chk(d, 32'(frames), "frame count");
    $display("test status done");
    test_done();
  end
endmodule
